// File: core/dacc_top.sv
// Dual array capture/compare unit with APB register access
//
// The implementer's own choices: the APB register port and the register offsets.

// How it works
// - 32 channels, single-cycle or staggered resolution
// - Two 16-bit timers per array, each reloadable
// - Timer clock: prescaler or auxiliary overflow
// - First timer per array takes external counts
// - 16 registers per array, timer and function selectable
// - Twelve second-array registers own a pin
// - Mode 0: interrupt only, many per period
// - Mode 1: pin toggles on every match
// - Mode 2: interrupt only, once per period
// - Mode 3: set on match, clear on overflow
// - Double mode: two registers toggle one pin
// - Single event option stops a compare channel after one match
// - Capture latches assigned timer on pin event
// - Each capture raises its own interrupt
// - Capture edge: rising, falling or both
// - Compare registers checked against timer on each timer tick
module dacc_top
    import dacc_pkg::*;
(
    // Clock and reset
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RST,
    // APB slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Timer clock sources
    input  wire logic        I_AUX_OVF,
    input  wire logic [1:0]  I_EXT_COUNT,
    // Channel pins
    input  wire logic [31:0] I_CC_PIN,
    output logic      [31:0] O_CC_PIN,
    output logic      [31:0] O_CC_PIN_OE_N,
    // Interrupt
    output logic             O_IRQ
);

    // ************************************************************
    // Decoding helpers
    // ************************************************************

    // Timer index owned by a channel: array picks the pair, mode bit the member
    function automatic logic [1:0] tsel(input int c, input logic [7:0] m);
        tsel = {(c >= ARR_CH), m[CM_TSEL]};
    endfunction

    // Function field of a channel mode
    function automatic logic [2:0] fn_of(input logic [7:0] m);
        fn_of = m[CM_FN_LSB +: 3];
    endfunction

    // Any of the compare functions
    function automatic logic is_cmp(input logic [7:0] m);
        is_cmp = (fn_of(m) >= FN_CMP0) && (fn_of(m) <= FN_CMP3);
    endfunction

    // Pin is an output for this mode
    function automatic logic drives(input logic [7:0] m);
        drives = (fn_of(m) == FN_CMP1) || (fn_of(m) == FN_CMP3)
               || (is_cmp(m) && m[CM_DOUBLE]);
    endfunction

    // Address map check; the low two address bits are ignored
    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a[11:2] == A_CTRL[11:2])
               || ((a >= A_TMR) && (a < A_ICLR + 12'h004))
               || ((a >= A_CHV) && (a < A_END));
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    dacc_state_s s;
    dacc_state_s n;

    logic [31:0] hit;
    logic [31:0] evt;
    logic [31:0] rise;
    logic [31:0] fall;
    logic [31:0] clr;
    logic [3:0]  tick;
    logic [1:0]  ext_edge;
    logic [7:0]  pmask;
    logic [2:0]  csel;
    logic [1:0]  t;
    logic [2:0]  f;
    logic        tgl;
    logic        once;
    logic        wr;
    logic        rd_setup;
    logic [4:0]  ci;
    logic [1:0]  ti;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        n        = s;
        hit      = '0;
        evt      = '0;
        tick     = '0;
        clr      = '0;
        pmask    = '0;
        csel     = '0;
        t        = '0;
        f        = '0;
        tgl      = 1'b0;
        once     = 1'b0;
        wr       = I_PSEL && I_PENABLE && I_PWRITE;
        rd_setup = I_PSEL && !I_PENABLE;
        ci       = I_PADDR[6:2];
        ti       = I_PADDR[3:2];
        ext_edge = I_EXT_COUNT & ~s.ext_q;
        rise     = I_CC_PIN & ~s.pin_q;
        fall     = ~I_CC_PIN & s.pin_q;
        n.ext_q  = I_EXT_COUNT;
        n.pin_q  = I_CC_PIN;
        n.pre    = s.pre + 8'h01;

        // Time bases; staggered mode passes prescaled ticks only in the one slot in eight set by STAG_PHASE
        for (int k = 0; k < NTMR; k++) begin
            csel  = s.tcfg[k][TC_SEL_LSB +: 3];
            pmask = 8'((1 << (PRE_STEP * int'(csel))) - 1);
            if (csel < CS_AUX) begin
                tick[k] = ((s.pre & pmask) == pmask)
                       && (!s.stag || s.pre[2:0] == STAG_PHASE);
            end else if (csel == CS_AUX) begin
                tick[k] = I_AUX_OVF;
            end else if (csel == CS_EXT && k % 2 == 0) begin
                tick[k] = ext_edge[k / 2];
            end
            tick[k]  = tick[k] && s.tcfg[k][TC_RUN];
            n.upd[k] = tick[k];
            n.ovf[k] = tick[k] && (s.tmr[k] == TMR_TOP);
            if (tick[k]) begin
                n.tmr[k] = (s.tmr[k] == TMR_TOP) ? s.rld[k] : s.tmr[k] + 16'h0001;
            end
        end

        // Software writes; a timer write wins over its tick
        if (wr) begin
            if (I_PADDR[11:2] == A_CTRL[11:2]) n.stag = I_PWDATA[0];
            if (I_PADDR[11:4] == A_TMR[11:4])  n.tmr[ti]  = I_PWDATA[15:0];
            if (I_PADDR[11:4] == A_RLD[11:4])  n.rld[ti]  = I_PWDATA[15:0];
            if (I_PADDR[11:4] == A_TCFG[11:4]) n.tcfg[ti] = I_PWDATA[7:0];
            if (I_PADDR[11:2] == A_IEN[11:2])  n.ien = I_PWDATA;
            if (I_PADDR[11:2] == A_ICLR[11:2]) clr   = I_PWDATA;
            if (I_PADDR[11:7] == A_CHV[11:7])  n.chv[ci] = I_PWDATA[15:0];
            if (I_PADDR[11:7] == A_CHM[11:7]) begin
                n.chm[ci]   = I_PWDATA[7:0];
                n.done[ci]  = 1'b0;    // Rewriting a mode rearms the channel
                n.spent[ci] = 1'b0;
            end
        end

        // Compare matches, evaluated on every timer tick
        for (int c = 0; c < NCH; c++) begin
            t    = tsel(c, s.chm[c]);
            f    = fn_of(s.chm[c]);
            once = (f == FN_CMP2) || (f == FN_CMP3);
            hit[c] = is_cmp(s.chm[c]) && s.upd[t] && (s.chv[c] == s.tmr[t])
                  && !s.spent[c] && !(once && s.done[c]);
        end

        // Channel actions
        for (int c = 0; c < NCH; c++) begin
            t = tsel(c, s.chm[c]);
            f = fn_of(s.chm[c]);
            // Overflow opens a new period and ends a mode 3 pulse
            if (s.ovf[t] && is_cmp(s.chm[c])) begin
                n.done[c] = 1'b0;
                if (f == FN_CMP3) n.pout[c] = 1'b0;
            end
            tgl = hit[c] && ((f == FN_CMP1) || s.chm[c][CM_DOUBLE]);
            if (c % ARR_CH < DBL_OFS && s.chm[c][CM_DOUBLE] && is_cmp(s.chm[c])) begin
                tgl = tgl ^ hit[c + DBL_OFS];
            end
            if (tgl) n.pout[c] = ~s.pout[c];
            if (hit[c]) begin
                evt[c]    = 1'b1;
                n.done[c] = 1'b1;
                if (f == FN_CMP3) n.pout[c] = 1'b1;
                if (s.chm[c][CM_SINGLE]) n.spent[c] = 1'b1;
            end
            // Capture on the selected pin transition
            if (f == FN_CAP && PIN_MASK[c]
                && ((s.chm[c][CM_EDGE_LSB] && rise[c])
                 || (s.chm[c][CM_EDGE_LSB + 1] && fall[c]))) begin
                n.chv[c] = s.tmr[t];
                evt[c]   = 1'b1;
            end
        end

        // Sticky status: a new event wins over a clear in the same cycle
        n.sts = (s.sts & ~clr) | evt;

        // Read data is latched during the setup phase for the access phase
        if (rd_setup) begin
            n.slverr = !addr_ok(I_PADDR);
            n.rdata  = '0;
            case (I_PADDR[11:7])
                A_CHV[11:7]: n.rdata = {16'h0000, s.chv[ci]};
                A_CHM[11:7]: n.rdata = {24'h00_0000, s.chm[ci]};
                A_CHM[11:7] + 5'h01: n.rdata = '0;
                default: begin
                    case (I_PADDR[11:4])
                        A_CTRL[11:4]: n.rdata = (I_PADDR[3:2] == 2'b00)
                                              ? {31'h0000_0000, s.stag} : '0;
                        A_TMR[11:4]:  n.rdata = {16'h0000, s.tmr[ti]};
                        A_RLD[11:4]:  n.rdata = {16'h0000, s.rld[ti]};
                        A_TCFG[11:4]: n.rdata = {24'h00_0000, s.tcfg[ti]};
                        A_STS[11:4]:  n.rdata = (I_PADDR[3:2] == 2'b00) ? s.sts
                                              : (I_PADDR[3:2] == 2'b01) ? s.ien : '0;
                        default:      n.rdata = '0;
                    endcase
                end
            endcase
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            s <= ST_RST;
        end else begin
            s <= n;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // Zero wait states keep the slave simple; data comes from the setup latch
    assign O_PREADY  = 1'b1;
    assign O_PRDATA  = s.rdata;
    assign O_PSLVERR = I_PSEL && I_PENABLE && s.slverr;
    assign O_IRQ     = |(s.sts & s.ien);

    // Pin drivers; channels without a pin stay released
    for (genvar g = 0; g < NCH; g++) begin : g_pin
        assign O_CC_PIN[g]      = s.pout[g] && PIN_MASK[g];
        assign O_CC_PIN_OE_N[g] = !(drives(s.chm[g]) && PIN_MASK[g]);
    end

endmodule

// File: core/dacc_pkg.sv
// Constants, field layouts and state type of the dual array capture/compare unit
package dacc_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int          NCH      = 32;              // Channels over both arrays
    localparam int          NTMR     = 4;               // Two time bases per array
    localparam int          ARR_CH   = 16;              // Registers per array
    localparam int          DBL_OFS  = 8;               // Partner distance in double mode
    localparam logic [31:0] PIN_MASK = 32'h0FFF_FFFF;   // Channels that own a pin
    localparam logic [15:0] TMR_TOP  = 16'hFFFF;        // Count value before overflow

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [11:0] A_CTRL = 12'h000;   // Bit 0: staggered mode
    localparam logic [11:0] A_TMR  = 12'h010;   // Four timer values
    localparam logic [11:0] A_RLD  = 12'h020;   // Four reload values
    localparam logic [11:0] A_TCFG = 12'h030;   // Four timer configurations
    localparam logic [11:0] A_STS  = 12'h040;   // Sticky event status, read only
    localparam logic [11:0] A_IEN  = 12'h044;   // Interrupt enable
    localparam logic [11:0] A_ICLR = 12'h048;   // Write one to clear status
    localparam logic [11:0] A_CHV  = 12'h080;   // 32 channel values
    localparam logic [11:0] A_CHM  = 12'h100;   // 32 channel modes
    localparam logic [11:0] A_END  = 12'h180;   // First unmapped address above

    // ************************************************************
    // Timer configuration fields
    // ************************************************************
    localparam int          TC_SEL_LSB = 0;     // Clock select, 3 bits
    localparam int          TC_RUN     = 3;     // Counter runs
    localparam logic [2:0]  CS_AUX     = 3'h4;  // Auxiliary timer overflow
    localparam logic [2:0]  CS_EXT     = 3'h5;  // External count input
    localparam int          PRE_STEP   = 2;     // Prescale grows by 4 per select step
    localparam logic [2:0]  STAG_PHASE = 3'h7;  // Staggered slot, one in eight

    // ************************************************************
    // Channel mode fields
    // ************************************************************
    localparam int          CM_TSEL     = 0;    // Time base a or b
    localparam int          CM_FN_LSB   = 1;    // Function, 3 bits
    localparam int          CM_EDGE_LSB = 4;    // Capture edge, 2 bits
    localparam int          CM_SINGLE   = 6;    // Single event
    localparam int          CM_DOUBLE   = 7;    // Double register master
    localparam logic [2:0]  FN_OFF      = 3'h0;
    localparam logic [2:0]  FN_CAP      = 3'h1;
    localparam logic [2:0]  FN_CMP0     = 3'h2;
    localparam logic [2:0]  FN_CMP1     = 3'h3;
    localparam logic [2:0]  FN_CMP2     = 3'h4;
    localparam logic [2:0]  FN_CMP3     = 3'h5;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [3:0][15:0]  tmr;
        logic [3:0][15:0]  rld;
        logic [3:0][7:0]   tcfg;
        logic              stag;
        logic [7:0]        pre;
        logic [3:0]        upd;
        logic [3:0]        ovf;
        logic [31:0][15:0] chv;
        logic [31:0][7:0]  chm;
        logic [31:0]       done;
        logic [31:0]       spent;
        logic [31:0]       pout;
        logic [31:0]       pin_q;
        logic [1:0]        ext_q;
        logic [31:0]       sts;
        logic [31:0]       ien;
        logic [31:0]       rdata;
        logic              slverr;
    } dacc_state_s;

    localparam dacc_state_s ST_RST = '0;    // Everything idle and cleared

endpackage

// File: test/dacc_far.sv
// Far-side pin model: external event levels merged with the unit's own outputs
module dacc_far (
    // Bench levels and unit outputs
    input  wire logic [31:0] i_lvl,
    input  wire logic [31:0] i_drv,
    input  wire logic [31:0] i_oe_n,
    // Levels seen at the unit's pin inputs
    output logic      [31:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // Pin resolution
    // ************************************************************
    // A driven pin reads back its own level, so a compare pin never fakes a capture
    assign o_pin = (i_drv & ~i_oe_n) | (i_lvl & i_oe_n);
endmodule

// File: test/dacc_chk.sv
// Port-level assertions of the dual array capture/compare unit
module dacc_chk import dacc_pkg::*; (
    // Clock and reset
    input wire logic        I_SYS_CLK,
    input wire logic        I_RST,
    // APB
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] O_PRDATA,
    input wire logic        O_PREADY,
    input wire logic        O_PSLVERR,
    // Pins and interrupt
    input wire logic [31:0] O_CC_PIN,
    input wire logic [31:0] O_CC_PIN_OE_N,
    input wire logic        O_IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RST);
    // Bus answers
    ready_high_a: assert property (O_PREADY)
        else $error("pready low");
    err_phase_a: assert property (O_PSLVERR |-> I_PSEL && I_PENABLE)
        else $error("pslverr outside access");
    hole_read_a: assert property (I_PSEL && I_PENABLE && I_PADDR >= A_END
        |-> O_PSLVERR && (I_PWRITE || O_PRDATA == 32'h0000_0000))
        else $error("unmapped access answered wrongly");
    rdata_hold_a: assert property (I_PSEL && I_PENABLE |=> $stable(O_PRDATA))
        else $error("read data moved after access");
    // Channels without a pin never drive
    nopin_oe_a: assert property (&O_CC_PIN_OE_N[31:28])
        else $error("pinless channel enabled");
    nopin_out_a: assert property (O_CC_PIN[31:28] == 4'h0)
        else $error("pinless channel level");
    // Idle after reset; interrupt only drops after software writes
    reset_idle_a: assert property ($past(I_RST) |-> !O_IRQ && O_CC_PIN == 32'h0000_0000)
        else $error("not idle after reset");
    irq_fall_a: assert property ($fell(O_IRQ) |-> $past(I_PSEL && I_PENABLE && I_PWRITE))
        else $error("irq fell without a write");
endmodule

bind dacc_top dacc_chk dacc_chk_i (.I_SYS_CLK, .I_RST, .I_PSEL, .I_PENABLE, .I_PWRITE,
    .I_PADDR, .O_PRDATA, .O_PREADY, .O_PSLVERR, .O_CC_PIN, .O_CC_PIN_OE_N, .O_IRQ);

// File: test/dacc_top_tb_top.sv
// Self-checking bench of the dual array capture/compare unit
module dacc_top_tb_top import dacc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // Stimulus and wiring
    // ************************************************************
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic        aux = 1'b0;
    logic [1:0]  ext = 2'b00;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] lvl = 32'h0000_0000;
    logic [31:0] q, prdata, pin_o, pin_i, oe_n;
    logic        pready, pslverr, irq, err;
    logic [15:0] v, rl, n;
    logic [2:0]  fns [5] = '{FN_CMP1, FN_CMP0, FN_CMP2, FN_CMP3, FN_CMP1};
    int          errors = 0;
    int          comparisons = 0;

    dacc_top dacc_top_i (.I_SYS_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_AUX_OVF(aux), .I_EXT_COUNT(ext),
        .I_CC_PIN(pin_i), .O_CC_PIN(pin_o), .O_CC_PIN_OE_N(oe_n), .O_IRQ(irq));
    dacc_far dacc_far_i (.i_lvl(lvl), .i_drv(pin_o), .i_oe_n(oe_n), .o_pin(pin_i));

    // 20 MHz clock
    initial begin
        forever #25 clk = ~clk;
    end

    // ************************************************************
    // Tasks and expectation functions
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // One APB transfer; the gap edge before setup avoids double drives
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 64);
        if (i >= 64) begin
            errors++;
            summarize();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // Ticks through an external count line (0, 1) or the auxiliary overflow (2)
    task automatic pulse(input int b, input int k);
        repeat (k) begin
            @(posedge clk);
            if (b == 2) aux <= 1'b1;
            else ext[b] <= 1'b1;
            @(posedge clk);
            aux <= 1'b0;
            ext <= 2'b00;
            repeat (3) @(posedge clk);
        end
        @(negedge clk);
    endtask

    function automatic logic [31:0] cm(logic [2:0] fn, logic [1:0] e, logic b, logic s);
        return {24'h00_0000, 1'b0, s, e, fn, b};
    endfunction

    function automatic logic [15:0] nxt(logic [15:0] t, logic [15:0] r);
        return (t == TMR_TOP) ? r : t + 16'h0001;
    endfunction

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'h2a23));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, A_END, 32'h0000_0000);
        check({q[30:0], err}, 32'h0000_0001);
        // Five compare channels on time base a, matching at v
        v = 16'($urandom_range(32'h0000_F000, 32'h0000_0100));
        rl = 16'($urandom_range(32'h0000_00FF, 32'h0000_0000));
        apb(1'b1, A_RLD, {16'h0000, rl});
        apb(1'b1, A_TMR, {16'h0000, v - 16'h0002});
        for (int c = 0; c < 5; c++) begin
            apb(1'b1, A_CHV + 12'(4 * c), {16'h0000, v});
            apb(1'b1, A_CHM + 12'(4 * c), cm(fns[c], 2'b00, 1'b0, 1'(c == 4)));
        end
        apb(1'b1, A_TCFG, 32'h0000_000D);
        pulse(0, 2);
        check(32'(oe_n[4:0]), 32'h0000_0006);
        check(32'(pin_o[4:0]), 32'h0000_0019);
        apb(1'b0, A_STS, 32'h0000_0000);
        check(q & 32'h0000_000F, 32'h0000_000F);
        apb(1'b0, A_TMR, 32'h0000_0000);
        check(q, {16'h0000, v});
        // Second match in the same period
        apb(1'b1, A_ICLR, 32'h0000_001F);
        apb(1'b1, A_TMR, {16'h0000, v - 16'h0001});
        pulse(0, 1);
        check(32'(pin_o[4:0]), 32'h0000_0018);
        apb(1'b0, A_STS, 32'h0000_0000);
        check(q & 32'h0000_000F, 32'h0000_0003);
        // Overflow reloads the timer and ends the set level
        apb(1'b1, A_TMR, 32'h0000_FFFE);
        pulse(0, 2);
        check(32'(pin_o[3]), 32'h0000_0000);
        apb(1'b0, A_TMR, 32'h0000_0000);
        check(q, {16'h0000, nxt(nxt(16'hFFFE, rl), rl)});
        // New period rearms the once-only modes
        apb(1'b1, A_TMR, {16'h0000, v - 16'h0001});
        pulse(0, 1);
        apb(1'b0, A_STS, 32'h0000_0000);
        check(q & 32'h0000_000F, 32'h0000_000F);
        check(32'(pin_o[4:0]), 32'h0000_0019);
        // Interrupt enable, then clear
        apb(1'b1, A_IEN, 32'h0000_0002);
        @(negedge clk);
        check(32'(irq), 32'h0000_0001);
        apb(1'b1, A_ICLR, 32'h0000_0002);
        @(negedge clk);
        check(32'(irq), 32'h0000_0000);
        // Captures on time base b, clocked by auxiliary overflows
        n = 16'($urandom_range(9, 3));
        apb(1'b1, A_TCFG + 12'h004, 32'h0000_000C);
        apb(1'b1, A_CHM + 12'h014, cm(FN_CAP, 2'b01, 1'b1, 1'b0));
        apb(1'b1, A_CHM + 12'h018, cm(FN_CAP, 2'b10, 1'b1, 1'b0));
        pulse(2, n);
        apb(1'b1, A_ICLR, 32'hFFFF_FFFF);
        lvl <= 32'h0000_0060;
        apb(1'b0, A_CHV + 12'h014, 32'h0000_0000);
        check(q, {16'h0000, n});
        apb(1'b0, A_STS, 32'h0000_0000);
        check(32'(q[6:5]), 32'h0000_0001);
        pulse(2, 1);
        @(posedge clk);
        lvl <= 32'h0000_0000;
        apb(1'b0, A_CHV + 12'h018, 32'h0000_0000);
        check(q, {16'h0000, n + 16'h0001});
        apb(1'b0, A_CHV + 12'h014, 32'h0000_0000);
        check(q, {16'h0000, n});
        // Double register pair 7 and 15 on time base a; only pin 7 is driven
        apb(1'b1, A_TMR, {16'h0000, v - 16'h0001});
        apb(1'b1, A_CHV + 12'h01C, {16'h0000, v});
        apb(1'b1, A_CHV + 12'h03C, {16'h0000, v + 16'h0001});
        apb(1'b1, A_CHM + 12'h01C, cm(FN_CMP0, 2'b00, 1'b0, 1'b0) | 32'h0000_0080);
        apb(1'b1, A_CHM + 12'h03C, cm(FN_CMP0, 2'b00, 1'b0, 1'b0));
        pulse(0, 1);
        check(32'({oe_n[15], oe_n[7]}), 32'h0000_0002);
        check(32'(pin_o[7]), 32'h0000_0001);
        pulse(0, 1);
        check(32'(pin_o[7]), 32'h0000_0000);
        // Staggered mode: array 2 time base a runs 83 edges, one tick in eight
        apb(1'b1, A_CTRL, 32'h0000_0001);
        apb(1'b1, A_TCFG + 12'h008, 32'h0000_0008);
        repeat (80) @(posedge clk);
        apb(1'b1, A_TCFG + 12'h008, 32'h0000_0000);
        apb(1'b0, A_TMR + 12'h008, 32'h0000_0000);
        check(32'(q >= 32'h0000_000A && q <= 32'h0000_000B), 32'h0000_0001);
        summarize();
    end
endmodule
